//--- tpr_pkg.sv
package tpr_pkg;
  // Number of pause classes: eight priorities plus global
  localparam int NUM_CLASS     = 9;
  // Index of the global pause class
  localparam int GLOBAL_IDX    = 8;
  // Width of quanta and refresh timer values
  localparam int QUANTA_W      = 16;
  // Reset value of quanta and refresh defaults
  localparam logic [15:0] QUANTA_RST  = 16'h0000;
  localparam logic [15:0] REFRESH_RST = 16'h0000;
  // Reset value of enable defaults
  localparam logic [8:0]  ENABLE_RST  = 9'h000;
  // Frame kind encoding on the pause frame output
  localparam logic FRAME_PRIORITY = 1'b0;
  localparam logic FRAME_GLOBAL   = 1'b1;
  // Transmit arbiter states
  typedef enum logic [1:0] {TPR_IDLE, TPR_DATA, TPR_PAUSE} tpr_state_t;
endpackage

//--- tpr_refresh.sv
`timescale 1ns/100ps
// One refresh timer per pause class; fires when a sent pause is due again
module tpr_refresh
  import tpr_pkg::*;
#(
  parameter int W = QUANTA_W
) (
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  input  wire logic         restart_i,   // Reload after send or resend
  input  wire logic         active_i,    // Class has a standing request
  input  wire logic [W-1:0] period_i,    // Refresh interval in cycles
  output logic              due_o        // Refresh time reached
);
  logic [W-1:0] count;       // Cycles left until refresh
  logic [W-1:0] next_count;
  logic         next_due;

  // Next count: reload on restart, count down while active
  always_comb begin
    next_count = count;
    next_due   = 1'b0;
    if (restart_i || !active_i) begin
      next_count = period_i;
    end else if (count != '0) begin
      next_count = count - W'(1);
    end else begin
      next_due   = (period_i != '0);
    end
  end

  // Register the counter
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      count <= W'(REFRESH_RST);
      due_o <= 1'b0;
    end else begin
      count <= next_count;
      due_o <= next_due;
    end
  end
endmodule

//--- tpr_tx_pause_ctrl.sv
`timescale 1ns/100ps
module tpr_tx_pause_ctrl
  import tpr_pkg::*;
#(
  parameter int  NC      = NUM_CLASS,
  parameter int  W       = QUANTA_W,
  parameter bit  USE_REG = 1'b0   // When set, settings come from internal defaults
) (
  input  wire logic            CLK_I,
  input  wire logic            RESET_I,
  input  wire logic [NC-1:0]   PAUSE_REQ_I,       // Pause request per class
  input  wire logic [NC-1:0]   PAUSE_ENABLE_I,    // Pause enable per class
  input  wire logic            RESEND_PAUSE_I,    // One-cycle resend strobe
  input  wire logic [NC*W-1:0] PAUSE_QUANTA_I,    // Quanta, class k at k*W
  input  wire logic [NC*W-1:0] REFRESH_TIMER_I,   // Refresh per class
  input  wire logic            DATA_SOF_I,        // Data frame wants to start
  input  wire logic            DATA_EOF_I,        // Data frame last cycle
  input  wire logic            PAUSE_DONE_I,      // Frame builder finished
  output logic                 DATA_GRANT_O,      // Data frame may start
  output logic                 PAUSE_VALID_O,     // Pause frame being sent
  output logic                 PAUSE_KIND_O,      // Global or priority
  output logic [NC-2:0]        PAUSE_CLASS_O,     // Priority classes in frame
  output logic [NC*W-1:0]      PAUSE_FRAME_QUANTA_O, // Quanta for frame
  output logic [NC-1:0]        PAUSE_PENDING_O    // Classes awaiting send
);
  tpr_state_t        state;        // Arbiter state
  tpr_state_t        next_state;
  logic [NC-1:0]     pending;      // Classes with a frame owed
  logic [NC-1:0]     next_pending;
  logic [NC-1:0]     req_q;        // Previous request, for edge detect
  logic [NC-1:0]     enable;       // Effective enables
  logic [NC*W-1:0]   quanta;       // Effective quanta
  logic [NC*W-1:0]   period;       // Effective refresh periods
  logic [NC-1:0]     due;          // Refresh timers due
  logic [NC-1:0]     sent;         // Classes sent this cycle
  logic              next_valid;
  logic              next_kind;
  logic [NC-2:0]     next_class;
  logic [NC*W-1:0]   next_fq;
  logic              next_grant;

  // Direct ports or internal defaults for the settings
  assign enable = USE_REG ? {NC{ENABLE_RST[0]}} : PAUSE_ENABLE_I;
  assign quanta = USE_REG ? {NC{W'(QUANTA_RST)}} : PAUSE_QUANTA_I;
  assign period = USE_REG ? {NC{W'(REFRESH_RST)}} : REFRESH_TIMER_I;

  // One refresh timer per class
  for (genvar k = 0; k < NC; k++) begin : g_timer
    tpr_refresh #(.W(W)) u_refresh (
      .clk_i     (CLK_I),
      .reset_i   (RESET_I),
      .restart_i (RESEND_PAUSE_I || sent[k]),
      .active_i  (PAUSE_REQ_I[k] && enable[k]),
      .period_i  (period[k*W +: W]),
      .due_o     (due[k])
    );
  end

  // Classes served when a pause frame starts
  always_comb begin
    sent = '0;
    if (state == TPR_IDLE && !(DATA_SOF_I && next_grant)) begin
      if (pending[GLOBAL_IDX]) begin
        sent[GLOBAL_IDX] = 1'b1;
      end else begin
        sent[NC-2:0] = pending[NC-2:0];
      end
    end
  end

  // Pending set logic; new event wins over the clear
  always_comb begin
    next_pending = pending & ~sent;
    next_pending = next_pending |
                   (PAUSE_REQ_I & ~req_q) | due;
    if (RESEND_PAUSE_I) begin
      next_pending = next_pending | PAUSE_REQ_I;
    end
    next_pending = next_pending & enable;
  end

  // Arbiter: pause frames only between data frames
  always_comb begin
    next_state = state;
    next_grant = 1'b0;
    next_valid = PAUSE_VALID_O;
    next_kind  = PAUSE_KIND_O;
    next_class = PAUSE_CLASS_O;
    next_fq    = PAUSE_FRAME_QUANTA_O;
    case (state)
      TPR_IDLE: begin
        if (pending != '0) begin
          // Pending pause goes ahead of a new data frame
          next_state = TPR_PAUSE;
          next_valid = 1'b1;
          next_kind  = pending[GLOBAL_IDX] ? FRAME_GLOBAL
                                           : FRAME_PRIORITY;
          next_class = pending[GLOBAL_IDX] ? '0 : pending[NC-2:0];
          next_fq    = quanta;
        end else if (DATA_SOF_I) begin
          next_state = TPR_DATA;
          next_grant = 1'b1;
        end
      end
      TPR_DATA: begin
        next_grant = 1'b1;
        if (DATA_EOF_I) begin
          // Data frame completes; arbitration reopens
          next_state = TPR_IDLE;
          next_grant = 1'b0;
        end
      end
      TPR_PAUSE: begin
        if (PAUSE_DONE_I) begin
          next_state = TPR_IDLE;
          next_valid = 1'b0;
        end
      end
      default: begin
        next_state = TPR_IDLE;
      end
    endcase
  end

  // Register state and outputs
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      state                <= TPR_IDLE;
      pending              <= '0;
      req_q                <= '0;
      DATA_GRANT_O         <= 1'b0;
      PAUSE_VALID_O        <= 1'b0;
      PAUSE_KIND_O         <= FRAME_PRIORITY;
      PAUSE_CLASS_O        <= '0;
      PAUSE_FRAME_QUANTA_O <= '0;
      PAUSE_PENDING_O      <= '0;
    end else begin
      state                <= next_state;
      pending              <= next_pending;
      req_q                <= PAUSE_REQ_I;
      DATA_GRANT_O         <= next_grant;
      PAUSE_VALID_O        <= next_valid;
      PAUSE_KIND_O         <= next_kind;
      PAUSE_CLASS_O        <= next_class;
      PAUSE_FRAME_QUANTA_O <= next_fq;
      PAUSE_PENDING_O      <= next_pending;
    end
  end

  // Checks sample on the rising clock and rest during reset
  default clocking cb_chk @(posedge CLK_I);
  endclocking
  default disable iff (RESET_I);

  // Disabled class never holds a pending frame
  a_no_disabled_pend: assert property (
    (pending & ~$past(enable)) == '0)
    else $error("pending set for disabled class");
  // Request edge on enabled class 3 is remembered
  a_req_makes_pend: assert property (
    (PAUSE_REQ_I[3] && !req_q[3] && enable[3])
      |=> pending[3] || PAUSE_VALID_O)
    else $error("request edge not recorded");
  // A frame stands until the builder reports it done
  a_valid_stands: assert property (
    PAUSE_VALID_O && !PAUSE_DONE_I |=> PAUSE_VALID_O)
    else $error("pause frame dropped early");
  // Pause frame never overlaps a data frame
  a_no_pause_in_data: assert property (
    (state == TPR_DATA) |-> !PAUSE_VALID_O)
    else $error("pause overlaps data frame");
  // Data is never granted while a pause frame runs
  a_grant_idle: assert property (
    (state == TPR_PAUSE) |-> !DATA_GRANT_O)
    else $error("data granted during pause");
  // Global pending goes out as a global frame
  a_global_kind: assert property (
    $rose(PAUSE_VALID_O) && $past(pending[GLOBAL_IDX])
      |-> PAUSE_KIND_O == FRAME_GLOBAL)
    else $error("global pause sent as priority");
  // Global frame carries no priority classes
  a_global_alone: assert property (
    PAUSE_VALID_O && PAUSE_KIND_O == FRAME_GLOBAL
      |-> PAUSE_CLASS_O == '0)
    else $error("global frame names priorities");
  // Priority frame carries every pending priority class
  a_prio_class: assert property (
    $rose(PAUSE_VALID_O) && !$past(pending[GLOBAL_IDX])
      |-> PAUSE_CLASS_O == $past(pending[NC-2:0]))
    else $error("priority classes not carried");
  // Frame quanta are the class quanta at frame start
  a_quanta_loaded: assert property (
    $rose(PAUSE_VALID_O) |-> PAUSE_FRAME_QUANTA_O == $past(quanta))
    else $error("frame quanta not captured");
  // Resend outside idle marks every requested enabled class
  a_resend_pend: assert property (
    (RESEND_PAUSE_I && state != TPR_IDLE)
      |=> (($past(PAUSE_REQ_I) & $past(enable)) & ~pending) == '0)
    else $error("resend did not mark pending");
  // Resend restarts every refresh timer
  a_resend_restart: assert property (
    RESEND_PAUSE_I |=> (due == '0) [*2])
    else $error("timer due right after resend");

  // Main scenarios
  c_global_sent: cover property (
    $rose(PAUSE_VALID_O) && PAUSE_KIND_O == FRAME_GLOBAL);
  c_prio_sent: cover property (
    $rose(PAUSE_VALID_O) && PAUSE_KIND_O == FRAME_PRIORITY);
  c_resend_in_data: cover property (
    RESEND_PAUSE_I && state == TPR_DATA);
  c_refresh_due: cover property (
    due != '0);
endmodule

//--- tpr_builder_model.sv
`timescale 1ns/100ps
// Frame builder stand-in: finishes each pause frame after a delay
module tpr_builder_model (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       valid_i,   // Pause frame outstanding
  input  wire logic [3:0] delay_i,   // Cycles before finishing
  output logic            done_o     // One-cycle finish pulse
);
  logic [3:0] cnt = 4'h0;            // Cycles spent on this frame

  // Count while a frame stands, pulse once, then wait for release
  always @(negedge clk_i) begin
    done_o <= 1'b0;
    if (reset_i || !valid_i) begin
      cnt <= 4'h0;
    end else if (!done_o && cnt != 4'hf) begin
      if (cnt == delay_i) begin
        done_o <= 1'b1;
        cnt    <= 4'hf;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule

//--- tx_pause_request_control_tb_top.sv
`timescale 1ns/100ps
module tx_pause_request_control_tb_top;
  import tpr_pkg::*;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic [8:0]   req = 9'h000;      // Requests per class
  logic [8:0]   ena = 9'h1ff;      // Enables per class
  logic         resend = 1'b0;     // Resend strobe
  logic         sof = 1'b0;        // Data frame waiting
  logic         eof = 1'b0;        // Data frame last cycle
  logic [143:0] quanta = '0;       // Quanta per class
  logic [143:0] refresh = '0;      // Refresh per class
  logic [3:0]   dly = 4'h2;        // Builder delay
  logic         done, grant, valid, kind;
  logic [7:0]   cls;
  logic [143:0] fq;
  logic [8:0]   pend;
  logic [8:0]   pend_r;            // Pending of the internal-settings copy
  int           n_fail = 0;
  int           tests_run = 0;
  int           k;
  int           t;

  // Free-running clock
  always #5 clk = ~clk;

  tpr_tx_pause_ctrl DUT (.CLK_I(clk), .RESET_I(rst), .PAUSE_REQ_I(req),
    .PAUSE_ENABLE_I(ena), .RESEND_PAUSE_I(resend), .PAUSE_QUANTA_I(quanta),
    .REFRESH_TIMER_I(refresh), .DATA_SOF_I(sof), .DATA_EOF_I(eof),
    .PAUSE_DONE_I(done), .DATA_GRANT_O(grant), .PAUSE_VALID_O(valid),
    .PAUSE_KIND_O(kind), .PAUSE_CLASS_O(cls), .PAUSE_FRAME_QUANTA_O(fq),
    .PAUSE_PENDING_O(pend));

  tpr_builder_model builder (.clk_i(clk), .reset_i(rst), .valid_i(valid),
    .delay_i(dly), .done_o(done));

  // Copy with internal settings; its enables default to off
  tpr_tx_pause_ctrl #(.USE_REG(1'b1)) DUT_REG (.CLK_I(clk), .RESET_I(rst),
    .PAUSE_REQ_I(req), .PAUSE_ENABLE_I(ena), .RESEND_PAUSE_I(resend),
    .PAUSE_QUANTA_I(quanta), .REFRESH_TIMER_I(refresh), .DATA_SOF_I(sof),
    .DATA_EOF_I(eof), .PAUSE_DONE_I(1'b0), .DATA_GRANT_O(),
    .PAUSE_VALID_O(), .PAUSE_KIND_O(), .PAUSE_CLASS_O(),
    .PAUSE_FRAME_QUANTA_O(), .PAUSE_PENDING_O(pend_r));

  // Value comparison
  task cmp(input logic [15:0] act, input logic [15:0] exp);
    tests_run++;
    if (act !== exp) begin
      n_fail++;
      $display("[ERR] %0t act=%h exp=%h", $time, act, exp);
    end
  endtask

  // Bounded wait for the frame flag to reach a level
  task wait_valid(input logic lvl, input int lim);
    t = 0;
    while (valid !== lvl && t < lim) begin
      @(negedge clk);
      t++;
    end
    cmp(16'(valid), 16'(lvl));
  endtask

  task report_and_stop;
    if (n_fail == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Hang guard
  initial begin
    #20000;
    n_fail++;
    report_and_stop;
  end

  // Main sequence
  initial begin
    for (k = 0; k < 9; k++) begin
      quanta[16*k +: 16] = 16'(16'h1111 * (k + 1));
    end
    refresh[16 +: 16] = 16'h0028;  // Class 1 refreshed every 40 cycles
    repeat (10) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    // Each class alone: one frame, right kind, class and quanta
    for (k = 0; k < 9; k++) begin
      req[k] = 1'b1;
      @(negedge clk);
      cmp(16'(pend), 16'(9'h001 << k));
      cmp(16'(pend_r), 16'h0000);
      wait_valid(1'b1, 5);
      cmp(16'(kind), 16'(k == 8));
      cmp(16'(cls), (k == 8) ? 16'h0 : 16'(8'h01 << k));
      cmp(fq[16*k +: 16], 16'(16'h1111 * (k + 1)));
      wait_valid(1'b0, 20);
      req[k] = 1'b0;
      repeat (5) @(negedge clk);
      cmp(16'(valid), 16'h0);
    end
    // Disabled class stays silent
    ena[3] = 1'b0;
    req[3] = 1'b1;
    repeat (6) @(negedge clk);
    cmp(16'(pend), 16'h0);
    cmp(16'(valid), 16'h0);
    req[3] = 1'b0;
    ena[3] = 1'b1;
    // Request and resend during a data frame wait for its end
    sof = 1'b1;
    repeat (2) @(negedge clk);
    cmp(16'(grant), 16'h1);
    sof = 1'b0;
    req[1] = 1'b1;
    repeat (6) @(negedge clk);
    cmp(16'(valid), 16'h0);
    cmp(16'(pend), 16'h002);
    eof = 1'b1;
    @(negedge clk);
    eof = 1'b0;
    cmp(16'(grant), 16'h0);
    wait_valid(1'b1, 5);
    wait_valid(1'b0, 20);
    sof = 1'b1;
    repeat (2) @(negedge clk);
    sof = 1'b0;
    resend = 1'b1;
    @(negedge clk);
    resend = 1'b0;
    repeat (4) @(negedge clk);
    cmp(16'(valid), 16'h0);
    cmp(16'(pend), 16'h002);
    eof = 1'b1;
    @(negedge clk);
    eof = 1'b0;
    wait_valid(1'b1, 5);
    cmp(16'(cls), 16'h02);
    // Refresh re-sends a standing request, slow builder
    dly = 4'h9;
    wait_valid(1'b0, 20);
    repeat (20) @(negedge clk);
    cmp(16'(valid), 16'h0);
    wait_valid(1'b1, 60);
    wait_valid(1'b0, 20);
    resend = 1'b1;
    @(negedge clk);
    resend = 1'b0;
    wait_valid(1'b1, 5);
    wait_valid(1'b0, 20);
    repeat (20) @(negedge clk);
    cmp(16'(valid), 16'h0);
    wait_valid(1'b1, 40);
    req[1] = 1'b0;
    wait_valid(1'b0, 20);
    report_and_stop;
  end
endmodule
